// file: psufc_pkg.sv
/*
  Constants, encodings and types shared by the three-module power stage
  PWM controller. Assumes nothing of its surroundings.
*/
package psufc_pkg;

  localparam int unsigned PSUFC_NMOD = 3;
  localparam int unsigned PSUFC_CW = 12;
  localparam int unsigned PSUFC_FILT_LEN = 4;

  localparam logic [11:0] PSUFC_CNT_RST = 12'h000;
  localparam logic [11:0] PSUFC_CNT_ONE = 12'h001;
  localparam logic [7:0] PSUFC_PRE_RST = 8'h00;
  localparam logic [3:0] PSUFC_FILT_RST = 4'h0;

  // Prescaler encodings and the last count of each divide ratio
  localparam logic [1:0] PSUFC_PRE_DIV1 = 2'h0;
  localparam logic [1:0] PSUFC_PRE_DIV4 = 2'h1;
  localparam logic [1:0] PSUFC_PRE_DIV32 = 2'h2;
  localparam logic [1:0] PSUFC_PRE_DIV256 = 2'h3;
  localparam logic [7:0] PSUFC_LAST_DIV1 = 8'h00;
  localparam logic [7:0] PSUFC_LAST_DIV4 = 8'h03;
  localparam logic [7:0] PSUFC_LAST_DIV32 = 8'h1F;
  localparam logic [7:0] PSUFC_LAST_DIV256 = 8'hFF;

  // Input mode field
  localparam logic [2:0] PSUFC_MODE_IGNORE = 3'h0;
  localparam logic [2:0] PSUFC_MODE_KILL_A = 3'h1;
  localparam logic [2:0] PSUFC_MODE_KILL_B = 3'h2;
  localparam logic [2:0] PSUFC_MODE_KILL_AB = 3'h3;
  localparam logic [1:0] PSUFC_MODE_HI_ALL = 2'h2;
  localparam logic [1:0] PSUFC_MODE_HI_HALT = 2'h3;

  // ADC sync source select
  localparam logic [1:0] PSUFC_ADC_LEAD_A = 2'h0;
  localparam logic [1:0] PSUFC_ADC_TRAIL_A = 2'h1;
  localparam logic [1:0] PSUFC_ADC_LEAD_B = 2'h2;
  localparam logic [1:0] PSUFC_ADC_TRAIL_B = 2'h3;

  typedef enum logic [1:0]
  {
    PSUFC_ST_STOP = 2'b00,
    PSUFC_ST_UP = 2'b01,
    PSUFC_ST_DOWN = 2'b11
  } psufc_state_type;

endpackage : psufc_pkg

// file: psufc_input.sv
/*
  Fault input conditioning for one module: polarity, optional digital
  filter and active-onset event detection.
  Assumes the pin is synchronous to CLOCK_I and tick_i is the controller
  clock enable.
*/
`timescale 1ns/100ps
`default_nettype none

module psufc_input
  import psufc_pkg::*;
(
  input wire logic clk_i,     // System clock
  input wire logic rst_n_i,   // Async reset, active low
  input wire logic tick_i,    // Controller clock enable
  input wire logic pin_i,     // Raw fault input
  input wire logic pol_i,     // 1: high/rising active
  input wire logic filt_en_i, // Filter enable
  output logic active_o,      // Active level after conditioning
  output logic event_o        // Onset of active level, one cycle
);

  logic [3:0] shift_r;
  logic filt_r;
  logic prev_r;
  logic act_pin;

  assign act_pin = pin_i ~^ pol_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      shift_r <= PSUFC_FILT_RST;
    else if (tick_i)
      shift_r <= {shift_r[2:0], act_pin};
  end

  // Level changes only after four equal controller-clock samples
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      filt_r <= 1'b0;
    else if (tick_i && (&shift_r))
      filt_r <= 1'b1;
    else if (tick_i && !(|shift_r))
      filt_r <= 1'b0;
  end

  assign active_o = filt_en_i ? filt_r : act_pin;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_r <= 1'b0;
    else if (tick_i)
      prev_r <= active_o;
  end

  assign event_o = tick_i && active_o && !prev_r;

  AST_FILTER_HOLDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (filt_en_i && tick_i && (shift_r == 4'h0) && !filt_r) |=> !filt_r)
    else $error("filter output rose without four active samples");

endmodule : psufc_input

`default_nettype wire

// file: psufc_top.sv
/*
  Three-module power stage PWM controller: prescaled controller clock,
  shared 12-bit counter, shadowed compare sets with end-of-cycle update,
  overlap protection, fault inputs, ADC sync pulses and event pulses.
  Assumes all inputs synchronous to CLOCK_I; PLL_TICK_I is an enable
  marking each edge of the PLL clock.
*/
`timescale 1ns/100ps
`default_nettype none

module psufc_top
  import psufc_pkg::*;
(
  input wire logic CLOCK_I,                     // 100 MHz clock
  input wire logic RESET_N_I,                   // Async reset, active low
  input wire logic PLL_TICK_I,                  // PLL clock edge enable
  input wire logic CLOCK_SOURCE_SELECT_I,       // 0 I/O clock, 1 PLL
  input wire logic [1:0] PRESCALER_I,           // Divide select
  input wire logic RUN_I,                       // Counter run
  input wire logic CENTERED_MODE_I,             // 0 one ramp, 1 centered
  input wire logic UPDATE_HOLD_I,               // Blocks shadow transfer
  input wire logic OUTPUT_POL_A_I,              // A outputs active high
  input wire logic OUTPUT_POL_B_I,              // B outputs active high
  input wire logic [2:0] OUTPUT_A_CONNECT_I,    // Connect A per module
  input wire logic [2:0] OUTPUT_B_CONNECT_I,    // Connect B per module
  input wire logic [2:0] EXTRA_RAMP_CONFIG_I,   // B mirrors A inverted
  input wire logic [2:0][11:0] SET_POINT_A_I,   // A set compares
  input wire logic [2:0][11:0] RESET_POINT_A_I, // A reset compares
  input wire logic [2:0][11:0] SET_POINT_B_I,   // B set compares
  input wire logic [11:0] RESET_POINT_B_I,      // B reset and counter top
  input wire logic [2:0] OVERLAP_DISABLE_I,     // 1 removes protection
  input wire logic [2:0] FAULT_INPUT_I,         // Fault pins
  input wire logic [2:0] FILTER_EN_I,           // Input filter enable
  input wire logic [2:0] INPUT_POL_I,           // Input polarity
  input wire logic [2:0] EDGE_MODE_I,           // 1 edge, 0 level
  input wire logic [2:0][2:0] INPUT_MODE_I,     // Input mode field
  input wire logic [2:0] ASYNC_KILL_I,          // Direct output kill
  input wire logic [2:0] RUN_SET_I,             // Run bit set pulse
  input wire logic [2:0][1:0] ADC_SEL_I,        // ADC sync source
  output logic [2:0] OUTPUT_A_O,                // Output A pins
  output logic [2:0] OUTPUT_B_O,                // Output B pins
  output logic [2:0] ADC_SYNC_PULSE_O,          // ADC sync pulses
  output logic [2:0] END_IRQ_O,                 // Counter reload pulse
  output logic [2:0] FAULT_IRQ_O,               // Input event pulse
  output logic [2:0] SYNC_ERR_IRQ_O,            // Sync error pulse
  output logic [2:0] HALTED_O,                  // Module halted
  output logic [11:0] COUNTER_O                 // Counter value
);

  psufc_state_type state_r;
  logic [7:0] pre_cnt_r;
  logic [7:0] pre_last;
  logic [11:0] cnt_r;
  logic [11:0] top_r;
  logic src_tick;
  logic tick;
  logic running;
  logic end_cyc;
  logic load;
  logic win_a;
  logic win_b;
  wire [2:0] halt_w;
  wire [2:0] kill_all_w;
  wire [2:0] evt_w;

  always_comb
  begin
    unique case (PRESCALER_I)
      PSUFC_PRE_DIV1: pre_last = PSUFC_LAST_DIV1;
      PSUFC_PRE_DIV4: pre_last = PSUFC_LAST_DIV4;
      PSUFC_PRE_DIV32: pre_last = PSUFC_LAST_DIV32;
      PSUFC_PRE_DIV256: pre_last = PSUFC_LAST_DIV256;
    endcase
  end

  assign src_tick = CLOCK_SOURCE_SELECT_I ? PLL_TICK_I : 1'b1;
  assign tick = src_tick && (pre_cnt_r >= pre_last);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      pre_cnt_r <= PSUFC_PRE_RST;
    else if (tick)
      pre_cnt_r <= PSUFC_PRE_RST;
    else if (src_tick)
      pre_cnt_r <= pre_cnt_r + 8'h01;
  end

  // Any halted module stops the shared counter
  assign running = RUN_I && !(|halt_w);
  assign end_cyc = tick && (((state_r == PSUFC_ST_UP) && (cnt_r == top_r) &&
                   !CENTERED_MODE_I) || ((state_r == PSUFC_ST_DOWN) &&
                   (cnt_r == PSUFC_CNT_RST)));
  // Stopped counter takes new values at once so a restart uses them
  assign load = (end_cyc || (state_r == PSUFC_ST_STOP)) && !UPDATE_HOLD_I;
  assign win_a = !CENTERED_MODE_I || (state_r == PSUFC_ST_UP);
  assign win_b = !CENTERED_MODE_I || (state_r == PSUFC_ST_DOWN);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      top_r <= PSUFC_CNT_RST;
    else if (load)
      top_r <= RESET_POINT_B_I;
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_r <= PSUFC_ST_STOP;
      cnt_r <= PSUFC_CNT_RST;
    end
    else if (!running)
    begin
      state_r <= PSUFC_ST_STOP;
      cnt_r <= PSUFC_CNT_RST;
    end
    else if (tick)
    begin
      unique case (state_r)
        PSUFC_ST_STOP:
          state_r <= PSUFC_ST_UP;
        PSUFC_ST_UP:
          if (cnt_r != top_r)
            cnt_r <= cnt_r + PSUFC_CNT_ONE;
          else if (!CENTERED_MODE_I)
            cnt_r <= PSUFC_CNT_RST;
          else
          begin
            state_r <= PSUFC_ST_DOWN;
            cnt_r <= (cnt_r == PSUFC_CNT_RST) ? cnt_r : cnt_r - PSUFC_CNT_ONE;
          end
        PSUFC_ST_DOWN:
          if (cnt_r != PSUFC_CNT_RST)
            cnt_r <= cnt_r - PSUFC_CNT_ONE;
          else
          begin
            state_r <= PSUFC_ST_UP;
            cnt_r <= (top_r == PSUFC_CNT_RST) ? cnt_r : PSUFC_CNT_ONE;
          end
        default:
          state_r <= PSUFC_ST_STOP;
      endcase
    end
  end

  assign COUNTER_O = cnt_r;

  genvar n;
  generate
    for (n = 0; n < PSUFC_NMOD; n++)
    begin : g_mod
      logic [11:0] sa_r;
      logic [11:0] ra_r;
      logic [11:0] sb_r;
      logic con_a_r;
      logic con_b_r;
      logic xramp_r;
      logic act;
      logic evt;
      logic fault_r;
      logic halt_r;
      logic raw_a;
      logic raw_b;
      logic kill_a;
      logic kill_b;
      logic async_kill;
      logic out_a_r;
      logic out_b_r;
      logic prev_a_r;
      logic prev_b_r;
      logic adc_hit;
      logic [2:0] mode;

      assign mode = INPUT_MODE_I[n];

      always_ff @(posedge CLOCK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          sa_r <= PSUFC_CNT_RST;
          ra_r <= PSUFC_CNT_RST;
          sb_r <= PSUFC_CNT_RST;
          con_a_r <= 1'b0;
          con_b_r <= 1'b0;
          xramp_r <= 1'b0;
        end
        else if (load)
        begin
          sa_r <= SET_POINT_A_I[n];
          ra_r <= RESET_POINT_A_I[n];
          sb_r <= SET_POINT_B_I[n];
          con_a_r <= OUTPUT_A_CONNECT_I[n];
          con_b_r <= OUTPUT_B_CONNECT_I[n];
          xramp_r <= EXTRA_RAMP_CONFIG_I[n];
        end
      end

      psufc_input u_input
      (
        .clk_i(CLOCK_I),
        .rst_n_i(RESET_N_I),
        .tick_i(tick),
        .pin_i(FAULT_INPUT_I[n]),
        .pol_i(INPUT_POL_I[n]),
        .filt_en_i(FILTER_EN_I[n]),
        .active_o(act),
        .event_o(evt)
      );

      // Edge mode latches until cycle end (retrigger style); level follows pin
      always_ff @(posedge CLOCK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
          fault_r <= 1'b0;
        else if (EDGE_MODE_I[n])
          fault_r <= evt || (fault_r && !end_cyc);
        else
          fault_r <= act;
      end

      // Set wins over the software run pulse
      always_ff @(posedge CLOCK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
          halt_r <= 1'b0;
        else if (evt && (mode[2:1] == PSUFC_MODE_HI_HALT))
          halt_r <= 1'b1;
        else if (RUN_SET_I[n])
          halt_r <= 1'b0;
      end

      assign halt_w[n] = halt_r;
      assign evt_w[n] = evt && (mode != PSUFC_MODE_IGNORE);
      assign kill_all_w[n] = fault_r && (mode[2:1] == PSUFC_MODE_HI_ALL);
      assign kill_a = fault_r && win_a && ((mode == PSUFC_MODE_KILL_A) ||
                      (mode == PSUFC_MODE_KILL_AB));
      assign kill_b = fault_r && win_b && ((mode == PSUFC_MODE_KILL_B) ||
                      (mode == PSUFC_MODE_KILL_AB));

      always_comb
      begin
        if (CENTERED_MODE_I)
        begin
          raw_a = cnt_r < sa_r;
          raw_b = (cnt_r >= sb_r) && (cnt_r <= top_r);
        end
        else
        begin
          raw_a = (cnt_r >= sa_r) && (cnt_r < ra_r);
          raw_b = (cnt_r >= sb_r) && (cnt_r < top_r);
        end
        if (xramp_r)
          raw_b = !raw_a;
        if (!OVERLAP_DISABLE_I[n] && raw_a)
          raw_b = 1'b0;
        if (state_r == PSUFC_ST_STOP)
        begin
          raw_a = 1'b0;
          raw_b = 1'b0;
        end
      end

      always_ff @(posedge CLOCK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          out_a_r <= 1'b0;
          out_b_r <= 1'b0;
        end
        else
        begin
          out_a_r <= raw_a && !kill_a && !(|kill_all_w) && !(|halt_w);
          out_b_r <= raw_b && !kill_b && !(|kill_all_w) && !(|halt_w);
        end
      end

      // Bypasses every flop so a stopped controller clock cannot delay it
      assign async_kill = ASYNC_KILL_I[n] && (mode != PSUFC_MODE_IGNORE) &&
                          (FAULT_INPUT_I[n] ~^ INPUT_POL_I[n]);
      assign OUTPUT_A_O[n] = (out_a_r && con_a_r && !async_kill) ~^ OUTPUT_POL_A_I;
      assign OUTPUT_B_O[n] = (out_b_r && con_b_r && !async_kill) ~^ OUTPUT_POL_B_I;

      always_comb
      begin
        if (CENTERED_MODE_I)
          adc_hit = tick && (cnt_r == ra_r) && !ADC_SEL_I[n][1] &&
                    ((state_r == PSUFC_ST_UP) == ADC_SEL_I[n][0]);
        else
          unique case (ADC_SEL_I[n])
            PSUFC_ADC_LEAD_A: adc_hit = out_a_r && !prev_a_r;
            PSUFC_ADC_TRAIL_A: adc_hit = !out_a_r && prev_a_r;
            PSUFC_ADC_LEAD_B: adc_hit = out_b_r && !prev_b_r;
            PSUFC_ADC_TRAIL_B: adc_hit = !out_b_r && prev_b_r;
          endcase
      end

      always_ff @(posedge CLOCK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          prev_a_r <= 1'b0;
          prev_b_r <= 1'b0;
          ADC_SYNC_PULSE_O[n] <= 1'b0;
          END_IRQ_O[n] <= 1'b0;
          FAULT_IRQ_O[n] <= 1'b0;
          SYNC_ERR_IRQ_O[n] <= 1'b0;
        end
        else
        begin
          prev_a_r <= out_a_r;
          prev_b_r <= out_b_r;
          ADC_SYNC_PULSE_O[n] <= adc_hit;
          END_IRQ_O[n] <= end_cyc;
          FAULT_IRQ_O[n] <= evt_w[n];
          // Run pulse to a module that is not halted, while another module is halted, breaks the lockstep
          SYNC_ERR_IRQ_O[n] <= RUN_SET_I[n] && !halt_r && (|halt_w);
        end
      end
    end
  endgenerate

  assign HALTED_O = halt_w;

  sequence s_halt_event;
    g_mod[0].evt && (INPUT_MODE_I[0][2:1] == PSUFC_MODE_HI_HALT);
  endsequence

  sequence s_halt_effect;
    g_mod[0].halt_r ##1 (state_r == PSUFC_ST_STOP);
  endsequence

  AST_HOLD_NO_UPDATE: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    UPDATE_HOLD_I |=> $stable(g_mod[0].sa_r) && $stable(top_r))
    else $error("shadow transfer happened while hold was set");

  AST_UPDATE_AT_END: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (end_cyc && !UPDATE_HOLD_I) |=> (g_mod[0].sa_r == $past(SET_POINT_A_I[0])) &&
    (g_mod[1].sb_r == $past(SET_POINT_B_I[1])))
    else $error("compare set not taken at cycle end");

  AST_NO_MIDCYCLE_LOAD: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (!end_cyc && (state_r != PSUFC_ST_STOP)) |=> $stable(g_mod[2].ra_r))
    else $error("compare changed in mid cycle");

  AST_NO_OVERLAP: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !$past(OVERLAP_DISABLE_I[0]) |-> !(g_mod[0].out_a_r && g_mod[0].out_b_r))
    else $error("A and B active together with protection on");

  AST_HALT_STOPS: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (s_halt_event and !RUN_SET_I[0]) |=> s_halt_effect)
    else $error("halt event did not stop the controller");

  AST_HALT_INACTIVE: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    ($past(g_mod[0].halt_r) && !ASYNC_KILL_I[0]) |-> (OUTPUT_A_O[0] == !OUTPUT_POL_A_I))
    else $error("halted output not at inactive level");

  AST_IGNORE_MODE: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    ($past(INPUT_MODE_I[1]) == PSUFC_MODE_IGNORE) |-> !FAULT_IRQ_O[1])
    else $error("input event reported in ignore mode");

  AST_KILL_KEEPS_TIMING: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (g_mod[0].kill_a && tick && RUN_I && !(|halt_w) && (state_r == PSUFC_ST_UP) &&
    (cnt_r != top_r)) |=> (cnt_r == $past(cnt_r) + PSUFC_CNT_ONE) && !g_mod[0].out_a_r)
    else $error("kill mode disturbed the counter or left A active");

  AST_DIV32_SPACING: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (tick && !CLOCK_SOURCE_SELECT_I && (PRESCALER_I == PSUFC_PRE_DIV32)) |=> !tick [*8])
    else $error("divide by 32 ticks too close together");

endmodule : psufc_top

`default_nettype wire

// file: psufc_stage_model.sv
/*
  Far-side model: fault sensors feeding the input pins and a half-bridge
  stage that counts cross conduction. Assumes one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module psufc_stage_model
  import psufc_pkg::*;
(
  input wire logic clk_i,         // System clock
  input wire logic [2:0] out_a_i, // Output A pins
  input wire logic [2:0] out_b_i, // Output B pins
  input wire logic pol_a_i,       // A active high
  input wire logic pol_b_i,       // B active high
  input wire logic pol_in_i,      // Sensor active level
  input wire logic [2:0] trip_i,  // Sensor tripped
  output logic [2:0] fault_o,     // Fault pins
  output logic [7:0] shoot_o      // Cross conduction count
);
  logic [7:0] shoot_r = 8'h00;
  logic [2:0] both;

  // Sensor sits at its inactive level unless tripped
  assign fault_o = trip_i ^ {3{~pol_in_i}};
  assign both = (out_a_i ~^ {3{pol_a_i}}) & (out_b_i ~^ {3{pol_b_i}});
  assign shoot_o = shoot_r;

  always_ff @(posedge clk_i)
  begin
    if (|both)
      shoot_r <= shoot_r + 8'h01;
  end
endmodule : psufc_stage_model

`default_nettype wire

// file: tb.sv
/*
  Self-checking bench of the power stage controller: drives the config
  ports at the falling edge and watches outputs over whole cycles.
  Assumes the stage model beside it and no other stimulus.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import psufc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pll_tick = 1'b0, src_sel = 1'b0;
  logic run = 1'b0, hold = 1'b0, pol_a = 1'b1, pol_b = 1'b1, s_pol = 1'b1, ctr = 1'b0;
  logic [1:0] pre = 2'h0;
  logic [2:0] con_a = 3'h7, con_b = 3'h3, extra = 3'h0, ovl = 3'h4;
  logic [2:0] filt = 3'h0, edg = 3'h0, akill = 3'h0, run_set = 3'h0, trip = 3'h0;
  logic [2:0] fpin, oa, ob, adc, e_irq, f_irq, s_irq, halted;
  logic [2:0][2:0] mode = '0;
  logic [2:0][1:0] asel = '0;
  // Reset point A kept above zero throughout
  logic [2:0][11:0] sa = {3{12'h001}}, ra = {3{12'h004}}, sb = {3{12'h005}};
  logic [11:0] rb = 12'h009, cnt, cmax;
  logic [7:0] shoot, shoot0;
  int mismatches = 0, checks_done = 0, n_a[3], n_b[3], n_ab[3], n_fi, n_end, n_adc, n_mov, per;
  int divs[4] = '{1, 4, 32, 256};

  psufc_top dut_u (.CLOCK_I(clk), .RESET_N_I(rst_n), .PLL_TICK_I(pll_tick),
    .CLOCK_SOURCE_SELECT_I(src_sel), .PRESCALER_I(pre), .RUN_I(run), .CENTERED_MODE_I(ctr),
    .UPDATE_HOLD_I(hold), .OUTPUT_POL_A_I(pol_a), .OUTPUT_POL_B_I(pol_b),
    .OUTPUT_A_CONNECT_I(con_a), .OUTPUT_B_CONNECT_I(con_b), .EXTRA_RAMP_CONFIG_I(extra),
    .SET_POINT_A_I(sa), .RESET_POINT_A_I(ra), .SET_POINT_B_I(sb), .RESET_POINT_B_I(rb),
    .OVERLAP_DISABLE_I(ovl), .FAULT_INPUT_I(fpin), .FILTER_EN_I(filt),
    .INPUT_POL_I({3{s_pol}}), .EDGE_MODE_I(edg), .INPUT_MODE_I(mode), .ASYNC_KILL_I(akill),
    .RUN_SET_I(run_set), .ADC_SEL_I(asel), .OUTPUT_A_O(oa), .OUTPUT_B_O(ob),
    .ADC_SYNC_PULSE_O(adc), .END_IRQ_O(e_irq), .FAULT_IRQ_O(f_irq), .SYNC_ERR_IRQ_O(s_irq),
    .HALTED_O(halted), .COUNTER_O(cnt));

  psufc_stage_model stage_u (.clk_i(clk), .out_a_i(oa), .out_b_i(ob), .pol_a_i(pol_a),
    .pol_b_i(pol_b), .pol_in_i(s_pol), .trip_i(trip), .fault_o(fpin), .shoot_o(shoot));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // PLL edges every other system cycle
  always @(negedge clk)
    pll_tick <= ~pll_tick;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic watch(input int n);
    logic [11:0] last;
    logic [2:0] aa, ab;
    n_fi = 0;
    n_end = 0;
    n_adc = 0;
    n_mov = 0;
    cmax = 12'h000;
    n_a = '{0, 0, 0};
    n_b = '{0, 0, 0};
    n_ab = '{0, 0, 0};
    last = cnt;
    repeat (n)
    begin
      @(negedge clk);
      aa = oa ~^ {3{pol_a}};
      ab = ob ~^ {3{pol_b}};
      for (int m = 0; m < 3; m++)
      begin
        n_a[m] += aa[m];
        n_b[m] += ab[m];
        n_ab[m] += aa[m] & ab[m];
      end
      n_fi += f_irq[0];
      n_end += e_irq[0];
      n_adc += adc[0];
      n_mov += (cnt !== last);
      cmax = (cnt > cmax) ? cnt : cmax;
      last = cnt;
    end
  endtask : watch

  task automatic period(output int c);
    c = 0;
    for (int k = 0; k < 3000 && e_irq[0] !== 1'b1; k++)
      @(negedge clk);
    @(negedge clk);
    c = 1;
    while (e_irq[0] !== 1'b1 && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
  endtask : period

  task automatic pulse(input int n);
    trip[0] = 1'b1;
    repeat (n) @(negedge clk);
    trip[0] = 1'b0;
  endtask : pulse

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  initial
  begin
    #900000;
    mismatches++;
    give_verdict;
  end

  initial
  begin
    repeat (4) @(negedge clk);
    check({oa, ob, halted, cnt}, 21'h0);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    run = 1'b1;
    repeat (20) @(negedge clk);
    watch(10);
    check({n_end, cmax}, {32'd1, 12'h009});
    check({n_a[0] > 0, n_a[0] < 10, n_b[2]}, {1'b1, 1'b1, 32'd0});
    for (int s = 0; s < 4; s++)
    begin
      asel = {3{s[1:0]}};
      repeat (12) @(negedge clk);
      watch(10);
      check(n_adc, 1);
    end
    // Centered: reset point A marks one match per cycle in the chosen direction, none for a B select
    ctr = 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      asel = {3{s[1:0]}};
      repeat (20) @(negedge clk);
      watch(18);
      check({n_adc, cmax}, {(s < 2) ? 32'd1 : 32'd0, 12'h009});
    end
    ctr = 1'b0;
    asel = '0;
    sb[0] = 12'h002;
    for (int d = 0; d < 2; d++)
    begin
      ovl[0] = d[0];
      repeat (12) @(negedge clk);
      watch(20);
      check({n_ab[0] > 0, n_b[0] > 0}, {d[0], 1'b1});
    end
    sb[0] = 12'h005;
    ovl[0] = 1'b0;
    for (int p = 0; p < 5; p++)
    begin
      // Last pass runs the PLL source undivided
      src_sel = (p == 4);
      pre = p[1:0];
      period(per);
      period(per);
      check(per, (p == 4) ? 20 : 10 * divs[p]);
    end
    // Overlap seen at the stage only while protection was off
    shoot0 = shoot;
    check(shoot0 > 0, 1'b1);
    src_sel = 1'b0;
    pre = 2'h0;
    repeat (12) @(negedge clk);
    hold = 1'b1;
    rb = 12'h005;
    con_a[0] = 1'b0;
    extra[1] = 1'b1;
    watch(30);
    check({cmax, n_a[0] > 0}, {12'h009, 1'b1});
    hold = 1'b0;
    watch(20);
    watch(20);
    check({cmax, n_a[0]}, {12'h005, 32'd0});
    check(n_a[1] + n_b[1], 20);
    con_a[0] = 1'b1;
    extra[1] = 1'b0;
    run = 1'b0;
    rb = 12'h007;
    @(negedge clk);
    // Stop, reload and restart a fresh cycle
    run = 1'b1;
    watch(20);
    check(cmax, 12'h007);
    rb = 12'h009;
    repeat (20) @(negedge clk);
    for (int md = 0; md < 8; md++)
    begin
      mode[0] = md[2:0];
      trip[0] = 1'b1;
      watch(6);
      check(n_fi > 0, md != 0);
      watch(12);
      check({n_a[0] > 0, n_b[0] > 0, n_a[1] > 0}, {md != 1 && md < 3, md < 2, md < 4});
      check({n_mov > 0, halted[0]}, {md < 6, md > 5});
      trip[0] = 1'b0;
      repeat (5) @(negedge clk);
      check(halted[0], md > 5);
      run_set = 3'h3;
      @(negedge clk);
      run_set = 3'h0;
      check(s_irq, {1'b0, md > 5, 1'b0});
      repeat (12) @(negedge clk);
      check(halted, 3'h0);
    end
    s_pol = 1'b0;
    mode[0] = 3'h3;
    trip[0] = 1'b1;
    watch(6);
    watch(12);
    check(n_a[0] + n_b[0], 0);
    trip[0] = 1'b0;
    s_pol = 1'b1;
    mode[0] = 3'h1;
    filt[0] = 1'b1;
    repeat (12) @(negedge clk);
    fork
      pulse(2);
      watch(16);
    join
    check({n_fi > 0, n_a[0] > 0}, 2'h1);
    fork
      pulse(6);
      watch(16);
    join
    check(n_fi > 0, 1'b1);
    // Edge mode keeps a one-cycle pulse in force until cycle end
    filt[0] = 1'b0;
    edg[0] = 1'b1;
    repeat (12) @(negedge clk);
    for (int k = 0; k < 20 && e_irq[0] !== 1'b1; k++)
      @(negedge clk);
    fork
      pulse(1);
      watch(8);
    join
    check({n_fi, n_a[0]}, {32'd1, 32'd0});
    edg[0] = 1'b0;
    akill[0] = 1'b1;
    for (int k = 0; k < 20 && ob[0] !== pol_b; k++)
      @(negedge clk);
    check(ob[0], pol_b);
    trip[0] = 1'b1;
    #1;
    check({oa[0], ob[0]}, {~pol_a, ~pol_b});
    @(negedge clk);
    trip[0] = 1'b0;
    check(shoot, shoot0);
    give_verdict;
  end
endmodule : tb

`default_nettype wire
